// >>> logic/trps_pkg.sv
// Package of constants for the three-rail power sequencer
`default_nettype none
package trps_pkg;
    // ------------------------------------------------------------
    // Timing in timing-clock ticks, widths, counts and masks
    // ------------------------------------------------------------
    localparam int unsigned FIRST_DELAY_TICKS = 9;
    localparam int unsigned STEP_DELAY_TICKS  = 8;
    localparam int unsigned TICK_CNT_W        = 4;
    localparam int unsigned RAIL_COUNT        = 3;
    localparam int unsigned SYNC_STAGES       = 3;
    localparam logic [3:0]  TICK_ZERO         = 4'h0;
    localparam logic [3:0]  TICK_ONE          = 4'h1;
    localparam logic [2:0]  RAILS_NONE        = 3'h0;
    localparam logic [2:0]  RAILS_ALL         = 3'h7;
    localparam logic [2:0]  SYNC_RESET        = 3'h0;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TRPS_IDLE,
        TRPS_UP,
        TRPS_ON,
        TRPS_DOWN
    } trps_state_type;
endpackage : trps_pkg
`default_nettype wire

// >>> logic/trps_sync.sv
// Three-stage synchroniser with agreement of last two stages
`default_nettype none
module trps_sync
    import trps_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Asynchronous level in, filtered level out
    input  wire logic async_in,
    output var  logic level_out
);
    logic [2:0] stage_r;
    logic       level_r;
    wire        agree = (stage_r[1] == stage_r[2]);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_r <= SYNC_RESET;
            level_r <= 1'b0;
        end else begin
            stage_r <= {stage_r[1:0], async_in};
            if (agree) begin
                level_r <= stage_r[2];
            end
        end
    end

    assign level_out = level_r;
endmodule : trps_sync
`default_nettype wire

// >>> logic/trps_sequencer.sv
// Three-rail power sequencer core
//
// Behaviour
// [RULE1] All rails inactive after reset until enable; with polarity high, rails driven low (active) until polarity synchronised
// [RULE2] First rail releases nine to ten ticks after enable
// [RULE3] Second rail eight ticks after first, tick-aligned
// [RULE4] Third rail eight ticks after second
// [RULE5] Shutdown reverse order: nine-ten, eight, eight
// [RULE6] Timer starts on enable rising edge
// [RULE7] Early enable drop resets timer, outputs stay
// [RULE8] Drop mid power-up reverses released rails only
// [RULE9] Polarity low active high, high active low
// [RULE10] Open-drain rails: release undriven, deactivate low; with polarity high the code drives active rails low and releases inactive ones
// [RULE11] System drives polarity select, never floating
// [RULE12] Tick input; enable synchronised before edge detect
// [RULE13] Inactive level follows selected polarity; reset drives all rails low until polarity synchronised
`default_nettype none
module trps_sequencer
    import trps_pkg::*;
#(
    parameter int unsigned FIRST_TICKS = FIRST_DELAY_TICKS,
    parameter int unsigned STEP_TICKS  = STEP_DELAY_TICKS
)(
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control pins
    input  wire logic enable_in,
    input  wire logic output_polarity_select,
    input  wire logic timing_tick,
    // Open-drain rails: pin level, drive value, enable
    input  wire logic rail_out_first_in,
    input  wire logic rail_out_second_in,
    input  wire logic rail_out_third_in,
    output var  logic rail_out_first,
    output var  logic rail_out_second,
    output var  logic rail_out_third,
    output var  logic rail_out_first_oe,
    output var  logic rail_out_second_oe,
    output var  logic rail_out_third_oe
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (FIRST_TICKS < 2 || FIRST_TICKS > 15 ||
        STEP_TICKS < 1 || STEP_TICKS > 15) begin : g_bad_ticks
        $error("trps_sequencer: tick counts out of range");
    end
    localparam logic [3:0] FIRST_LOAD = 4'(FIRST_TICKS);
    localparam logic [3:0] STEP_LOAD  = 4'(STEP_TICKS);

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    logic en_s;
    logic pol_s;
    logic en_d_r;
    // [RULE12] Enable through synchroniser
    trps_sync u_en_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (enable_in),
        .level_out(en_s)
    );
    // [RULE11] Polarity assumed driven
    trps_sync u_pol_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (output_polarity_select),
        .level_out(pol_s)
    );
    wire en_rise = en_s & ~en_d_r;
    wire en_fall = ~en_s & en_d_r;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    trps_state_type state_r;
    trps_state_type state_nxt;
    logic [3:0]     cnt_r;
    logic [3:0]     cnt_nxt;
    logic [2:0]     act_r;
    logic [2:0]     act_nxt;
    wire            cnt_done = timing_tick && (cnt_r == TICK_ONE);
    wire            cnt_dec  = timing_tick && (cnt_r != TICK_ZERO);

    always_comb begin
        state_nxt = state_r;
        act_nxt   = act_r;
        cnt_nxt   = cnt_dec ? cnt_r - TICK_ONE : cnt_r;
        case (state_r)
            TRPS_IDLE: begin
                // [RULE6] Start timer on rise
                if (en_rise) begin
                    state_nxt = TRPS_UP;
                    cnt_nxt   = FIRST_LOAD;
                end
            end
            TRPS_UP: begin
                if (!en_s) begin
                    // [RULE7] Early drop resets timer
                    if (act_r == RAILS_NONE) begin
                        state_nxt = TRPS_IDLE;
                        cnt_nxt   = TICK_ZERO;
                    // [RULE8] Orderly reverse shutdown
                    end else begin
                        state_nxt = TRPS_DOWN;
                        cnt_nxt   = FIRST_LOAD;
                    end
                // [RULE2] First release after nine to ten
                end else if (cnt_done) begin
                    // [RULE3] Next rail eight ticks on
                    act_nxt = {act_r[1:0], 1'b1};
                    cnt_nxt = STEP_LOAD;
                    // [RULE4] Third completes power-up
                    if (act_r[1]) begin
                        state_nxt = TRPS_ON;
                        cnt_nxt   = TICK_ZERO;
                    end
                end
            end
            TRPS_ON: begin
                if (en_fall || !en_s) begin
                    state_nxt = TRPS_DOWN;
                    cnt_nxt   = FIRST_LOAD;
                end
            end
            TRPS_DOWN: begin
                // [RULE5] Reverse order shutdown
                if (cnt_done) begin
                    act_nxt = {1'b0, act_r[2:1]};
                    cnt_nxt = STEP_LOAD;
                    if (act_r[1:0] == 2'b01 || act_r == RAILS_NONE) begin
                        state_nxt = TRPS_IDLE;
                        act_nxt   = RAILS_NONE;
                        cnt_nxt   = TICK_ZERO;
                    end
                end
            end
            default: begin
                state_nxt = TRPS_IDLE;
                act_nxt   = RAILS_NONE;
                cnt_nxt   = TICK_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        // [RULE1] Reset clears rail activity; pins driven low
        if (!arst_n) begin
            state_r <= TRPS_IDLE;
            cnt_r   <= TICK_ZERO;
            act_r   <= RAILS_NONE;
            en_d_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            act_r   <= act_nxt;
            en_d_r  <= en_s;
        end
    end

    // ------------------------------------------------------------
    // Open-drain output stage
    // ------------------------------------------------------------
    // [RULE9] Pin level high when active, inverted by polarity
    wire [2:0] lvl_nxt = pol_s ? ~act_nxt : act_nxt;
    logic [2:0] oe_r;
    always_ff @(posedge clk or negedge arst_n) begin
        // [RULE13] Reset drives low until polarity known
        if (!arst_n) begin
            oe_r <= RAILS_ALL;
        // [RULE10] Drive low for low level, else release
        end else begin
            oe_r <= ~lvl_nxt;
        end
    end
    assign rail_out_first     = 1'b0;
    assign rail_out_second    = 1'b0;
    assign rail_out_third     = 1'b0;
    assign rail_out_first_oe  = oe_r[0];
    assign rail_out_second_oe = oe_r[1];
    assign rail_out_third_oe  = oe_r[2];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    wire unused_pins = rail_out_first_in ^ rail_out_second_in ^ rail_out_third_in;

    a_idle_inactive: assert property ( // [RULE1]
        @(posedge clk) disable iff (!arst_n)
        (state_r == TRPS_IDLE) |-> (act_r == RAILS_NONE))
        else $error("Rail active while idle");
    a_first_start: assert property ( // [RULE6]
        @(posedge clk) disable iff (!arst_n)
        (state_r == TRPS_IDLE && en_rise) |=> (state_r == TRPS_UP && cnt_r == FIRST_LOAD))
        else $error("Timer not started on enable rise");
    a_release_order: assert property ( // [RULE3]
        @(posedge clk) disable iff (!arst_n)
        (act_r == 3'b000 || act_r == 3'b001 || act_r == 3'b011 || act_r == 3'b111))
        else $error("Rails out of order");
    a_step_rise: assert property ( // [RULE3]
        @(posedge clk) disable iff (!arst_n)
        (state_r == TRPS_UP && en_s && cnt_done && act_r == 3'b001) |=> (act_r == 3'b011))
        else $error("Second rail not released");
    a_glitch_reject: assert property ( // [RULE7]
        @(posedge clk) disable iff (!arst_n)
        (state_r == TRPS_UP && !en_s && act_r == RAILS_NONE) |=> (state_r == TRPS_IDLE))
        else $error("Glitch not rejected");
    a_abort_down: assert property ( // [RULE8]
        @(posedge clk) disable iff (!arst_n)
        (state_r == TRPS_UP && !en_s && act_r != RAILS_NONE) |=> (state_r == TRPS_DOWN))
        else $error("No reverse shutdown on abort");
    a_down_step: assert property ( // [RULE5]
        @(posedge clk) disable iff (!arst_n)
        (state_r == TRPS_DOWN && !cnt_done) |=> (act_r == $past(act_r)))
        else $error("Rail dropped early");
    a_polarity_pin: assert property ( // [RULE9]
        @(posedge clk) disable iff (!arst_n)
        (oe_r == ($past(pol_s) ? act_r : ~act_r)))
        else $error("Rail pin level wrong");
    a_first_bound: assert property ( // [RULE2]
        @(posedge clk) disable iff (!arst_n)
        (state_r == TRPS_UP && act_r == RAILS_NONE) |-> (cnt_r <= FIRST_LOAD))
        else $error("First delay counter overran");
    c_full_up: cover property (@(posedge clk) disable iff (!arst_n) act_r == RAILS_ALL);
    c_glitch: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == TRPS_UP && !en_s && act_r == RAILS_NONE);
    c_abort: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == TRPS_UP && !en_s && act_r != RAILS_NONE);
    c_inverted: cover property (@(posedge clk) disable iff (!arst_n) pol_s && act_r[2]);
endmodule : trps_sequencer
`default_nettype wire

// >>> dv/trps_rail_model.sv
// Enable pins of the three supplies with their pull-ups
`default_nettype none
module trps_rail_model (
    // Open-drain drive from the sequencer
    input  wire logic [2:0] drive,
    input  wire logic [2:0] oe,
    // Resolved pin levels
    output var  logic [2:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin[i] = oe[i] ? drive[i] : 1'b1;
        end
    end
endmodule : trps_rail_model
`default_nettype wire

// >>> dv/trps_sequencer_tb.sv
// Self-checking bench for the three-rail sequencer
`default_nettype none
module trps_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and wiring
    // ------------------------------------------------------------
    logic            clk         = 1'b0;
    logic            arst_n      = 1'b0;
    logic            en          = 1'b0;
    logic            pol         = 1'b0;
    logic            tick        = 1'b0;
    int              div         = 0;
    int              tick_cnt    = 0;
    int              num_errors  = 0;
    int              comparisons = 0;
    wire logic [2:0] drv;
    wire logic [2:0] oe;
    wire logic [2:0] pin;

    always #2.5 clk = ~clk;

    // Timing tick every eight clocks
    always @(posedge clk) begin
        #1;
        div = (div + 1) % 8;
        tick = (div == 0);
        if (div == 0) begin
            tick_cnt++;
        end
    end

    trps_sequencer dut (
        .clk(clk), .arst_n(arst_n), .enable_in(en), .output_polarity_select(pol),
        .timing_tick(tick), .rail_out_first_in(pin[0]), .rail_out_second_in(pin[1]),
        .rail_out_third_in(pin[2]), .rail_out_first(drv[0]), .rail_out_second(drv[1]),
        .rail_out_third(drv[2]), .rail_out_first_oe(oe[0]), .rail_out_second_oe(oe[1]),
        .rail_out_third_oe(oe[2])
    );

    trps_rail_model rails (.drive(drv), .oe(oe), .pin(pin));

    // ------------------------------------------------------------
    // Helpers and scenarios
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        comparisons++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk

    task automatic chk_pin(input logic [2:0] exp);
        chk(8'(pin), 8'(exp), 8'(exp));
    endtask : chk_pin

    task automatic wait_clk(input int c);
        repeat (c) @(posedge clk);
        #2;
    endtask : wait_clk

    task automatic set_en(input logic v);
        @(posedge clk);
        #1;
        en = v;
        #1;
    endtask : set_en

    task automatic wait_level(input int i, input logic lvl, output logic [7:0] n);
        int start;
        start = tick_cnt;
        for (int k = 0; k < 200 && pin[i] !== lvl; k++) begin
            wait_clk(1);
        end
        n = 8'(tick_cnt - start);
    endtask : wait_level

    task automatic t_up(input logic p);
        logic [7:0] n;
        set_en(1'b1);
        for (int i = 0; i < 3; i++) begin
            wait_level(i, ~p, n);
            chk(n, (i == 0) ? 8'h09 : 8'h08, (i == 0) ? 8'h0a : 8'h08);
            chk_pin((3'h7 >> (2 - i)) ^ {3{p}});
        end
    endtask : t_up

    task automatic t_down(input logic p);
        logic [7:0] n;
        set_en(1'b0);
        for (int i = 2; i >= 0; i--) begin
            wait_level(i, p, n);
            chk(n, (i == 2) ? 8'h09 : 8'h08, (i == 2) ? 8'h0a : 8'h08);
            chk_pin((3'h7 >> (3 - i)) ^ {3{p}});
        end
    endtask : t_down

    task automatic t_glitch();
        logic bad;
        bad = 1'b0;
        set_en(1'b1);
        for (int k = 0; k < 170; k++) begin
            if (k == 48) begin
                set_en(1'b0);
            end
            wait_clk(1);
            bad = bad | (pin !== 3'h0);
        end
        chk(8'(bad), 8'h00, 8'h00);
    endtask : t_glitch

    task automatic t_abort();
        logic [7:0] n;
        set_en(1'b1);
        wait_level(0, 1'b1, n);
        chk(n, 8'h09, 8'h0a);
        wait_clk(24);
        set_en(1'b0);
        wait_level(0, 1'b0, n);
        chk(n, 8'h09, 8'h0a);
        chk_pin(3'h0);
    endtask : t_abort

    task automatic t_pol();
        @(posedge clk);
        #1;
        pol = 1'b1;
        wait_clk(8);
        chk_pin(3'h7);
        chk(8'(drv), 8'h00, 8'h00);
    endtask : t_pol

    task automatic complete_run();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #1;
        arst_n = 1'b1;
        wait_clk(100);
        chk_pin(3'h0);
        t_glitch();
        t_up(1'b0);
        t_down(1'b0);
        t_abort();
        t_pol();
        t_up(1'b1);
        t_down(1'b1);
        complete_run();
    end

    // About 1300 clocks expected; allow fifteen times that
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
endmodule : trps_sequencer_tb
`default_nettype wire
